// ### rsm_map.svh
`ifndef RSM_MAP_SVH
`define RSM_MAP_SVH

// Bus clock period in ns.
`define RSM_CLK_PERIOD_NS   10
// Internal reset stretch after the synchronised reset input negates, in bus clocks.
`define RSM_STRETCH_CYC     128
// Reset-out pulse length of the reset instruction, in bus clocks.
`define RSM_RSTOUT_CYC      512

// Register byte offsets.
`define RSM_CTRL_OFS        12'h000
`define RSM_STATUS_OFS      12'h004
`define RSM_RDATA_OFS       12'h008

// Control register fields.
`define RSM_CTRL_RSTOUT_BIT 0

// Status register fields.
`define RSM_ST_INTRST_BIT   0
`define RSM_ST_RSTOUT_BIT   1
`define RSM_ST_MUX_BIT      2
`define RSM_ST_LATCH_BIT    3
`define RSM_ST_WEAK_LSB     4
`define RSM_ST_STATE_LSB    8

// Mode values seen only while hresetn is asserted, before strap tracking starts.
`define RSM_MODE_RESET      5'h1C

`endif

// ### rsm_pkg.sv
package rsm_pkg;

    typedef enum logic [2:0] {
        RSM_ST_RESET      = 3'b000,
        RSM_ST_WAIT_GRANT = 3'b001,
        RSM_ST_IDLE       = 3'b010,
        RSM_ST_ADDR       = 3'b011,
        RSM_ST_DATA       = 3'b100
    } rsm_state_t;

    // weak_group[2] data bus, [1] address bus and attributes, [0] control outputs.
    typedef struct packed {
        logic [2:0] weak_group;
        logic       mux_bus;
        logic       latch_mode;
    } rsm_mode_t;

    // Output enables are active low: low means the pin is driven.
    typedef struct packed {
        logic addr_oe_n;
        logic data_oe_n;
        logic bus_busy_n;
        logic bus_busy_oe_n;
        logic transfer_in_progress_n;
        logic transfer_in_progress_oe_n;
        logic transfer_acknowledge_n;
        logic transfer_acknowledge_oe_n;
    } rsm_pins_t;

endpackage

// ### rsm_ctrl.sv
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`include "rsm_map.svh"

module rsm_ctrl
    import rsm_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        reset_input_n,
    input  wire logic        cache_disable_strap,
    input  wire logic        mmu_disable_strap,
    input  wire logic [2:0]  interrupt_level_inputs,
    input  wire logic        bus_grant_n,
    input  wire logic        transfer_acknowledge_in_n,
    input  wire logic        transfer_error_ack_n,
    input  wire logic        read_data_latch_strobe,
    input  wire logic [31:0] data_in,
    input  wire logic        cycle_req,
    input  wire logic        cycle_write,
    input  wire logic [31:0] cycle_addr,
    input  wire logic [31:0] cycle_wdata,
    input  wire logic        snoop_ack_drive,
    output logic             cycle_done,
    output logic             cycle_error,
    output logic [31:0]      read_data,
    output logic [31:0]      addr_out,
    output logic [31:0]      data_out,
    output logic             write_out,
    output rsm_pins_t        pins,
    output rsm_mode_t        modes,
    output logic             internal_reset,
    output logic             reset_out_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    localparam int NSYNC = 9;

    logic [NSYNC-1:0] pin_meta;
    logic [NSYNC-1:0] pin_sync;
    logic             rst_sync;
    logic [4:0]       strap_sync;
    logic             grant_sync;
    logic             ack_sync;
    logic             err_sync;

    // Reset input and strobe-like bus pins settle before any decision is made.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 9'h1C0;
            pin_sync <= 9'h1C0;
        end else begin
            pin_meta <= {transfer_error_ack_n, transfer_acknowledge_in_n, bus_grant_n, reset_input_n,
                         cache_disable_strap, mmu_disable_strap, interrupt_level_inputs};
            pin_sync <= pin_meta;
        end
    end

    assign rst_sync   = pin_sync[5];
    assign strap_sync = pin_sync[4:0];
    assign grant_sync = !pin_sync[6];
    assign ack_sync   = !pin_sync[7];
    assign err_sync   = !pin_sync[8];

    ////////////////////////////////////////////////////////////////////////////
    // Internal reset stretch.

    logic [7:0] stretch_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            internal_reset <= 1'b1;
            stretch_cnt    <= 8'h00;
        end else if (!rst_sync) begin
            internal_reset <= 1'b1;
            stretch_cnt    <= 8'h00;
        end else if (internal_reset) begin
            stretch_cnt <= stretch_cnt + 8'h01;
            if (stretch_cnt == 8'(`RSM_STRETCH_CYC - 1)) begin
                internal_reset <= 1'b0;
            end
        end
    end

    stretch_len_a: assert property (@(posedge hclk) disable iff (!hresetn || !rst_sync)
        $rose(rst_sync) |-> ##127 internal_reset ##1 !internal_reset)
        else $error("internal reset stretch is not 128 cycles");

    ////////////////////////////////////////////////////////////////////////////
    // Mode capture.

    function automatic rsm_mode_t rsm_decode(input logic [4:0] s);
        rsm_mode_t m;
        m.weak_group = s[2:0];
        m.latch_mode = !s[3];
        m.mux_bus    = !s[4];
        return m;
    endfunction

    // Tracking while reset is held leaves the value seen at the negating edge.
    // The straps share the reset input's synchroniser delay, so both line up.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            modes <= `RSM_MODE_RESET;
        end else if (!rst_sync) begin
            modes <= rsm_decode(strap_sync);
        end
    end

    mode_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rst_sync && $past(rst_sync) |-> $stable(modes))
        else $error("modes changed outside reset");

    strap_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(rst_sync) |-> modes.mux_bus == !$past(strap_sync[4]) && modes.latch_mode == !$past(strap_sync[3]))
        else $error("strap decode wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencing.

    rsm_state_t state;
    logic       release_q;
    logic       busy;

    assign busy = (state == RSM_ST_ADDR) || (state == RSM_ST_DATA);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= RSM_ST_RESET;
            release_q <= 1'b0;
            addr_out  <= 32'h0000_0000;
            data_out  <= 32'h0000_0000;
            write_out <= 1'b0;
        end else begin
            release_q <= 1'b0;
            if (!rst_sync) begin
                state     <= RSM_ST_RESET;
                release_q <= busy;
            end else begin
                case (state)
                    RSM_ST_RESET: begin
                        if (!internal_reset) begin
                            state <= RSM_ST_WAIT_GRANT;
                        end
                    end
                    RSM_ST_WAIT_GRANT: begin
                        if (grant_sync) begin
                            state     <= RSM_ST_ADDR;
                            addr_out  <= 32'h0000_0000;
                            write_out <= 1'b0;
                        end
                    end
                    RSM_ST_IDLE: begin
                        if (cycle_req && grant_sync) begin
                            state     <= RSM_ST_ADDR;
                            addr_out  <= cycle_addr;
                            data_out  <= cycle_wdata;
                            write_out <= cycle_write;
                        end
                    end
                    RSM_ST_ADDR: begin
                        state <= RSM_ST_DATA;
                    end
                    RSM_ST_DATA: begin
                        // Acknowledge, error or the reset input ends a cycle; the latch strobe never does.
                        if (ack_sync || err_sync) begin
                            state <= RSM_ST_IDLE;
                        end
                    end
                    default: begin
                        state <= RSM_ST_RESET;
                    end
                endcase
            end
        end
    end

    // A reset that cuts a cycle short reports it as a normal completion.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cycle_done  <= 1'b0;
            cycle_error <= 1'b0;
        end else begin
            cycle_done  <= (busy && !rst_sync) || (state == RSM_ST_DATA && (ack_sync || err_sync));
            cycle_error <= rst_sync && state == RSM_ST_DATA && err_sync && !ack_sync;
        end
    end

    term_kill_a: assert property (@(posedge hclk) disable iff (!hresetn)
        busy && !rst_sync |=> state == RSM_ST_RESET && cycle_done && release_q)
        else $error("reset did not end the bus cycle");

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive. The weak_group setting is not used here, and no output enable follows the groups.

    always_comb begin
        pins.addr_oe_n                 = 1'b1;
        pins.data_oe_n                 = 1'b1;
        pins.bus_busy_n                = 1'b1;
        pins.bus_busy_oe_n             = 1'b1;
        pins.transfer_in_progress_n    = 1'b1;
        pins.transfer_in_progress_oe_n = 1'b1;
        pins.transfer_acknowledge_n    = 1'b1;
        pins.transfer_acknowledge_oe_n = 1'b1;
        if (release_q) begin
            // Pull the lines to their idle level before letting go, so a pull-up is not left to do it slowly.
            pins.bus_busy_oe_n             = 1'b0;
            pins.transfer_in_progress_oe_n = 1'b0;
            pins.transfer_acknowledge_oe_n = !snoop_ack_drive;
        end else if (!internal_reset && busy && rst_sync) begin
            pins.addr_oe_n                 = modes.mux_bus && state == RSM_ST_DATA;
            pins.data_oe_n                 = !(write_out && (state == RSM_ST_DATA || !modes.mux_bus));
            pins.bus_busy_n                = 1'b0;
            pins.bus_busy_oe_n             = 1'b0;
            pins.transfer_in_progress_n    = 1'b0;
            pins.transfer_in_progress_oe_n = 1'b0;
        end else if (!internal_reset && rst_sync && snoop_ack_drive && state == RSM_ST_IDLE) begin
            pins.transfer_acknowledge_n    = 1'b0;
            pins.transfer_acknowledge_oe_n = 1'b0;
        end
    end

    reset_hiz_a: assert property (@(posedge hclk) disable iff (!hresetn)
        internal_reset && !release_q |-> pins.addr_oe_n && pins.data_oe_n && pins.bus_busy_oe_n
            && pins.transfer_in_progress_oe_n && pins.transfer_acknowledge_oe_n && reset_out_n)
        else $error("driver active during internal reset");

    grant_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == RSM_ST_WAIT_GRANT |-> pins.addr_oe_n && pins.data_oe_n && pins.bus_busy_oe_n)
        else $error("bus driven before grant");

    mux_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        modes.mux_bus && state == RSM_ST_ADDR && rst_sync |=> pins.addr_oe_n || !rst_sync)
        else $error("address driven past first clock in multiplexed mode");

    bus_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
        release_q |-> !pins.bus_busy_oe_n && pins.bus_busy_n ##1 pins.bus_busy_oe_n)
        else $error("busy not driven idle before release");

    ////////////////////////////////////////////////////////////////////////////
    // Read data path.

    logic [31:0] latch_q;
    logic        latch_open;

    // The strobe gates the latch directly; its whole purpose is capture ahead of the clock edge.
    assign latch_open = !modes.latch_mode || read_data_latch_strobe;

    always_latch begin
        if (latch_open) begin
            latch_q = data_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_data <= 32'h0000_0000;
        end else if (state == RSM_ST_DATA && !write_out && (ack_sync || err_sync) && rst_sync) begin
            read_data <= latch_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset instruction.

    logic [8:0] rstout_cnt;
    logic       rstout_active;
    logic       ctrl_wr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rstout_active <= 1'b0;
            rstout_cnt    <= 9'h000;
        end else if (!rst_sync) begin
            rstout_active <= 1'b0;
            rstout_cnt    <= 9'h000;
        end else if (rstout_active) begin
            rstout_cnt <= rstout_cnt + 9'h001;
            if (rstout_cnt == 9'(`RSM_RSTOUT_CYC - 1)) begin
                rstout_active <= 1'b0;
            end
        end else if (ctrl_wr && hwdata[`RSM_CTRL_RSTOUT_BIT] && !internal_reset) begin
            rstout_active <= 1'b1;
            rstout_cnt    <= 9'h000;
        end
    end

    assign reset_out_n = !(rstout_active && rst_sync);

    rstout_len_a: assert property (@(posedge hclk) disable iff (!hresetn || !rst_sync)
        $rose(reset_out_n) |-> $past(rstout_cnt) == 9'h1FF)
        else $error("reset-out pulse not 512 cycles");

    rstout_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !rst_sync |-> reset_out_n ##1 !rstout_active)
        else $error("reset-out not negated by reset input");

    rstout_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !reset_out_n |-> !internal_reset && $stable(modes))
        else $error("reset instruction disturbed internal state");

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite register slave, zero wait states.

    logic [11:0] dp_addr;
    logic        dp_write;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_addr  <= 12'h000;
            dp_write <= 1'b0;
        end else begin
            dp_write <= hsel && hready && htrans[1] && hwrite;
            dp_addr  <= haddr[11:0];
        end
    end

    assign ctrl_wr   = dp_write && dp_addr == `RSM_CTRL_OFS;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[11:0])
                `RSM_STATUS_OFS: begin
                    hrdata <= {21'h000000, state, 1'b0, modes.weak_group,
                               modes.latch_mode, modes.mux_bus, rstout_active, internal_reset};
                end
                `RSM_RDATA_OFS: begin
                    hrdata <= read_data;
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

// ### rsm_far.sv
`timescale 1ns/1ns
// Reset circuit, strap pins and bus slaves seen from outside the device.
module rsm_far
    import rsm_pkg::*;
(
    input  wire logic  hclk,
    input  rsm_pins_t  pins,
    input  wire logic  write_out,
    output logic       reset_input_n,
    output logic       cache_disable_strap,
    output logic       mmu_disable_strap,
    output logic [2:0] interrupt_level_inputs,
    output logic       bus_grant_n,
    output logic       transfer_acknowledge_in_n,
    output logic       transfer_error_ack_n,
    output logic       read_data_latch_strobe,
    output logic [31:0] data_in
);
    logic [31:0] d1;
    logic [31:0] d2;
    int          dly;
    logic        err;
    logic        wr;
    logic        tip_on;

    assign tip_on = !pins.transfer_in_progress_oe_n && !pins.transfer_in_progress_n;

    initial begin
        {reset_input_n, bus_grant_n} = 2'b01;
        {transfer_acknowledge_in_n, transfer_error_ack_n, read_data_latch_strobe} = 3'b111;
        {interrupt_level_inputs, cache_disable_strap, mmu_disable_strap} = 5'h1F;
        data_in = 32'h0;
        {d1, d2} = 64'h0;
        dly = 0;
        err = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Straps return to working levels well before the stretch ends.
    task automatic hold_reset(input logic [4:0] strap);
        @(posedge hclk);
        reset_input_n <= 1'b0;
        bus_grant_n <= 1'b1;
        {interrupt_level_inputs, cache_disable_strap, mmu_disable_strap} <= strap;
        repeat (12) @(posedge hclk);
        reset_input_n <= 1'b1;
        fork
            begin
                repeat (20) @(posedge hclk);
                {interrupt_level_inputs, cache_disable_strap, mmu_disable_strap} <= ~strap;
            end
        join_none
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // The data lines move once the strobe is low, so only the latch can keep the first word.
    initial forever begin
        @(negedge hclk);
        if (tip_on) begin
            wr = write_out;
            @(posedge hclk);
            if (!wr)
                data_in <= d1;
            read_data_latch_strobe <= 1'b1;
            @(posedge hclk);
            read_data_latch_strobe <= 1'b0;
            @(posedge hclk);
            if (!wr)
                data_in <= d2;
            repeat (dly) @(posedge hclk);
            if (err)
                transfer_error_ack_n <= 1'b0;
            else
                transfer_acknowledge_in_n <= 1'b0;
            @(posedge hclk);
            {transfer_acknowledge_in_n, transfer_error_ack_n} <= 2'b11;
            repeat (20) begin
                @(negedge hclk);
                if (!tip_on)
                    break;
            end
            @(posedge hclk);
            data_in <= ~data_in;
            read_data_latch_strobe <= 1'b1;
        end
    end
endmodule

// ### rsm_ctrl_bench.sv
`timescale 1ns/1ns
`include "rsm_map.svh"
module rsm_ctrl_bench
    import rsm_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        reset_input_n;
    logic        cache_disable_strap;
    logic        mmu_disable_strap;
    logic [2:0]  interrupt_level_inputs;
    logic        bus_grant_n;
    logic        transfer_acknowledge_in_n;
    logic        transfer_error_ack_n;
    logic        read_data_latch_strobe;
    logic [31:0] data_in;
    logic        cycle_req;
    logic        cycle_write;
    logic [31:0] cycle_addr;
    logic [31:0] cycle_wdata;
    logic        snoop_ack_drive;
    logic        cycle_done;
    logic        cycle_error;
    logic [31:0] read_data;
    logic [31:0] addr_out;
    logic [31:0] data_out;
    logic        write_out;
    rsm_pins_t   pins;
    rsm_mode_t   modes;
    logic        internal_reset;
    logic        reset_out_n;
    int          fails;
    int          n_checks;
    logic [4:0]  strap;
    logic [31:0] rd;
    int          i;
    int          cnt;

    always #5 hclk = ~hclk;

    rsm_ctrl rsm_ctrl_i (.*, .hsize(3'h2), .hready(hreadyout), .hresp());
    rsm_far rsm_far_i (.*);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bail();
        fails++;
        close_out();
    endtask

    function automatic logic [4:0] mode_exp(input logic [4:0] s);
        return {s[4:2], ~s[1:0]};
    endfunction

    // Low status bits: weak groups, latch and multiplexed modes; reset flags are expected clear.
    function automatic logic [6:0] stat_exp(input logic [4:0] s);
        logic [6:0] v;
        v = 7'h00;
        v[`RSM_ST_MUX_BIT]       = !s[1];
        v[`RSM_ST_LATCH_BIT]     = !s[0];
        v[`RSM_ST_WEAK_LSB +: 3] = s[4:2];
        return v;
    endfunction

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        if (k >= 50)
            bail();
        r = hrdata;
    endtask

    task automatic wait_on(input int lim, input logic want_done);
        int k;
        for (k = 0; k < lim; k++) begin
            @(negedge hclk);
            if (want_done ? cycle_done === 1'b1 : pins[3:2] === 2'b00)
                return;
        end
        bail();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic core(input logic w, input logic e);
        logic [31:0] a;
        logic [31:0] d;
        a = $urandom;
        d = $urandom;
        @(posedge hclk);
        {cycle_req, cycle_write, cycle_addr, cycle_wdata} <= {1'b1, w, a, d};
        {rsm_far_i.d1, rsm_far_i.d2, rsm_far_i.err} <= {$urandom, $urandom, e};
        rsm_far_i.dly <= $urandom_range(3, 0);
        snoop_ack_drive <= 1'($urandom);
        wait_on(30, 1'b0);
        chk(pins.addr_oe_n, 0);
        @(posedge hclk);
        cycle_req <= 1'b0;
        @(negedge hclk);
        chk(pins.addr_oe_n, !strap[1]);
        if (w)
            chk(pins.data_oe_n, 0);
        wait_on(60, 1'b1);
        chk({write_out, cycle_error}, {w, e});
        chk(addr_out, a);
        if (w)
            chk(data_out, d);
        else if (!e)
            chk(read_data, strap[0] ? rsm_far_i.d2 : rsm_far_i.d1);
    endtask

    // Counts from the edge that releases the reset pin to the end of internal reset.
    task automatic do_reset(input logic ab);
        int k;
        logic saw;
        saw = 1'b0;
        fork
            rsm_far_i.hold_reset(strap);
            for (k = 0; k < 12; k++) begin
                @(negedge hclk);
                saw |= (cycle_done === 1'b1 && cycle_error === 1'b0);
            end
        join
        chk(saw, ab);
        k = 0;
        do begin
            @(negedge hclk);
            k++;
            if (k == 60)
                chk({pins & 8'hD5, reset_out_n}, {8'hD5, 1'b1});
        end while (internal_reset !== 1'b0 && k < 300);
        chk(k >= `RSM_STRETCH_CYC + 1 && k <= `RSM_STRETCH_CYC + 3, 1);
        repeat (3) begin
            @(negedge hclk);
            chk(pins & 8'hD5, 8'hD5);
        end
        @(posedge hclk);
        {rsm_far_i.bus_grant_n, rsm_far_i.dly, rsm_far_i.err} <= {1'b0, 32'h0, 1'b0};
        wait_on(60, 1'b1);
        chk(addr_out, 0);
        chk(modes, mode_exp(strap));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
        {cycle_req, cycle_write, cycle_addr, cycle_wdata, snoop_ack_drive} = '0;
        {fails, n_checks, strap} = '0;
        void'($urandom(42093));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            strap = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
            if (i == 3) begin
                @(posedge hclk);
                {cycle_req, cycle_write, rsm_far_i.dly, rsm_far_i.err} <= {1'b1, 1'b0, 32'h3C, 1'b0};
                wait_on(30, 1'b0);
                @(posedge hclk);
                cycle_req <= 1'b0;
            end
            do_reset(i == 3);
            repeat (6) core(1'($urandom), 1'b0);
            core(1'b0, 1'b1);
            ahb(1'b0, {20'h0, `RSM_STATUS_OFS}, 32'h0, rd);
            chk(rd[6:0], stat_exp(strap));
            ahb(1'b0, 32'hC, 32'h0, rd);
            chk(rd, 0);
        end
        ahb(1'b1, {20'h0, `RSM_CTRL_OFS}, 32'h1, rd);
        cnt = 0;
        repeat (700) begin
            @(negedge hclk);
            if (reset_out_n === 1'b0)
                cnt++;
            else if (cnt > 0)
                break;
        end
        chk(cnt, `RSM_RSTOUT_CYC);
        ahb(1'b0, {20'h0, `RSM_STATUS_OFS}, 32'h0, rd);
        chk(rd[6:0], stat_exp(strap));
        ahb(1'b1, {20'h0, `RSM_CTRL_OFS}, 32'h1, rd);
        repeat (20) @(negedge hclk);
        chk(reset_out_n, 0);
        fork
            do_reset(1'b0);
            begin
                repeat (4) @(negedge hclk);
                chk(reset_out_n, 1);
            end
        join
        close_out();
    end

    initial begin
        #200000;
        bail();
    end
endmodule
